/* File: src/frlws_pkg.sv */
package frlws_pkg;
    // Register byte offsets on the APB slave
    localparam logic [11:0] OFF_ADDR_LO = 12'h000;
    localparam logic [11:0] OFF_ADDR_HI = 12'h004;
    localparam logic [11:0] OFF_WORD_LO = 12'h008;
    localparam logic [11:0] OFF_WORD_HI = 12'h00C;
    localparam logic [11:0] OFF_CTRL1 = 12'h010;
    localparam logic [11:0] OFF_UNLOCK = 12'h014;
    // Control one field positions
    localparam int B_SPACE = 6;
    localparam int B_LOAD_ONLY = 5;
    localparam int B_FREE = 4;
    localparam int B_WERR = 3;
    localparam int B_PERMIT = 2;
    localparam int B_WR = 1;
    // Unlock keys and blank latch value
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] BLANK_WORD = 14'h3FFF;
    // Row geometry: 32 latches, ten row bits
    localparam int LATCHES = 32;
    localparam int IDX_W = 5;
    localparam int ROW_W = 10;
    localparam logic [4:0] LAST_IDX = 5'h1F;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_IDX = 5'h00;
    // Unlock progress, Gray along the key path
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_GOT1 = 2'b01,
        UL_ARMED = 2'b11
    } frlws_ul_t;
    // Operation sequencer, Gray along the commit path
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_STREAM = 2'b01,
        OP_WAIT = 2'b11,
        OP_CLEAR = 2'b10
    } frlws_op_t;
    // One word beat toward the flash array
    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [13:0] data;
    } frlws_beat_t;
    // Row command toward the flash array
    typedef struct packed {
        logic prog;
        logic erase;
        logic [9:0] row;
    } frlws_cmd_t;
endpackage : frlws_pkg

/* File: src/frlws_latch_bank.sv */
`timescale 1ns/10ps
module frlws_latch_bank
    import frlws_pkg::*;
#(
    parameter int N = LATCHES,
    parameter int W = 14
)(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic load, // Write one latch
    input wire logic [IDX_W-1:0] load_idx, // Latch to write
    input wire logic [W-1:0] load_data, // Word to store
    input wire logic blank_all, // Return every latch to blank
    input wire logic [IDX_W-1:0] rd_idx, // Latch to read
    output logic [W-1:0] rd_data // Selected latch
);
    logic [W-1:0] latch_ff [N];

    // One flop word per latch; blanking beats a same-cycle load
    for (genvar i = 0; i < N; i++)
    begin : g_latch
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                latch_ff[i] <= BLANK_WORD;
            else if (blank_all)
                latch_ff[i] <= BLANK_WORD;
            else if (load && load_idx == IDX_W'(i))
                latch_ff[i] <= load_data;
        end
    end

    assign rd_data = latch_ff[rd_idx];
endmodule : frlws_latch_bank

/* File: src/frlws_seq.sv */
// Overview of operation
// R1: Program commit never erases; erase is a separate whole-row operation.
// R2: One commit writes one to 32 latch words.
// R3: Address bits 14:5 pick the row, bits 4:0 pick the latch.
// R4: Every word of a commit lands in the one selected row.
// R5: After a program commit all latches return to 3FFF.
// R6: After an erase all latches return to 3FFF too.
// R7: Load-only set: unlocked start stores the data word, no flash write.
// R8: Load-only clear: unlocked start stores last word then programs the row.
// R9: No latch load or flash write without the full unlock sequence.
// R10: Software sets permit, picks flash space, sets load-only before loading.
// R11: Software writes data, unlocks, then increments the address per word.
// R12: Last word: clear load-only, write data, unlock to commit the row.
// R13: Partial changes: read row, modify, erase, reload latches, commit.
// R14: Unloaded latches stay blank, so partial loads are fine.
// R15: Unlock is 55h then AAh to the key register, then start, uninterrupted.
// R16: Protected target: start bit cleared, error flag set, no operation.
// R17: Space select 0 is program flash, 1 the other spaces; here a space 1 program or erase start is rejected with the error flag set.
// R18: Valid program rows run from word 0 to top of flash, 32-aligned.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
module frlws_seq
    import frlws_pkg::*;
#(
    parameter logic [9:0] FLASH_ROWS = 10'd192 // Rows in program flash
)(
    input wire logic pclk, // System clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [9:0] wp_rows, // Rows below this are protected
    input wire logic fl_done, // Flash finished the row operation
    output frlws_cmd_t fl_cmd, // Row command
    output frlws_beat_t fl_beat // Word beats of a commit
);
    logic [7:0] adr_lo_ff, adr_hi_ff, word_lo_ff, word_hi_ff;
    logic space_ff, latch_load_only_ff, free_ff, werr_ff, permit_ff, wr_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    frlws_ul_t ul_ff;
    frlws_op_t op_ff;
    logic [IDX_W-1:0] cnt_ff;
    frlws_cmd_t cmd_ff;
    frlws_beat_t beat_ff;
    logic [13:0] lat_rd;

    // Address map lookup, used for decode and for the error answer
    function automatic logic mapped(input logic [11:0] a);
        mapped = a == OFF_ADDR_LO || a == OFF_ADDR_HI || a == OFF_WORD_LO
              || a == OFF_WORD_HI || a == OFF_CTRL1 || a == OFF_UNLOCK;
    endfunction : mapped

    // Access taken only when idle: the CPU-stall behaviour becomes a wait state
    logic busy, acc, wr_acc, ctrl_wr, key_wr;
    assign busy = op_ff != OP_IDLE;
    assign acc = psel && penable && !pready_ff && !busy;
    assign wr_acc = acc && pwrite && mapped(paddr);
    assign ctrl_wr = wr_acc && paddr == OFF_CTRL1;
    assign key_wr = wr_acc && paddr == OFF_UNLOCK;

    // Start request and its decoded operation, from the value being written
    logic trig, do_load, do_prog, do_erase, bad_tgt, reject, nope;
    logic [9:0] row;
    assign row = {adr_hi_ff[6:0], adr_lo_ff[7:5]}; // R3
    assign trig = ctrl_wr && pwdata[B_WR] && pwdata[B_PERMIT] && ul_ff == UL_ARMED; // R9 R15
    assign nope = ctrl_wr && pwdata[B_WR] && ul_ff != UL_ARMED && ul_ff != UL_IDLE;
    assign bad_tgt = pwdata[B_SPACE] || row >= FLASH_ROWS || row < wp_rows; // R16 R17 R18
    assign do_load = trig && !pwdata[B_FREE] && pwdata[B_LOAD_ONLY]; // R7
    assign reject = trig && !do_load && bad_tgt; // R16
    assign do_prog = trig && !pwdata[B_FREE] && !pwdata[B_LOAD_ONLY] && !bad_tgt; // R8
    assign do_erase = trig && pwdata[B_FREE] && !bad_tgt; // R1

    // Unlock tracker; any other access in between drops it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ul_ff <= UL_IDLE;
        else if (acc)
        begin
            if (key_wr && pwdata[7:0] == KEY_FIRST && ul_ff == UL_IDLE) // R15
                ul_ff <= UL_GOT1;
            else if (key_wr && pwdata[7:0] == KEY_SECOND && ul_ff == UL_GOT1) // R15
                ul_ff <= UL_ARMED;
            else
                ul_ff <= UL_IDLE;
        end
    end

    // Address and data holding registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adr_lo_ff <= RST_BYTE;
            adr_hi_ff <= RST_BYTE;
            word_lo_ff <= RST_BYTE;
            word_hi_ff <= RST_BYTE;
        end
        else if (wr_acc)
        begin
            if (paddr == OFF_ADDR_LO)
                adr_lo_ff <= pwdata[7:0];
            if (paddr == OFF_ADDR_HI)
                adr_hi_ff <= {1'b0, pwdata[6:0]};
            if (paddr == OFF_WORD_LO)
                word_lo_ff <= pwdata[7:0];
            if (paddr == OFF_WORD_HI)
                word_hi_ff <= {2'b00, pwdata[5:0]};
        end
    end

    // Control one; hardware set of the error flag wins over a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {space_ff, latch_load_only_ff, free_ff, werr_ff, permit_ff, wr_ff} <= 6'h00;
        end
        else
        begin
            if (ctrl_wr)
            begin
                space_ff <= pwdata[B_SPACE];
                latch_load_only_ff <= pwdata[B_LOAD_ONLY];
                free_ff <= pwdata[B_FREE];
                permit_ff <= pwdata[B_PERMIT];
                werr_ff <= pwdata[B_WERR];
            end
            if (reject || nope)
                werr_ff <= 1'b1; // R16
            // Start bit reads 1 only while a row operation runs
            if (do_prog || do_erase)
                wr_ff <= 1'b1;
            else if (op_ff == OP_CLEAR || reject) // R16
                wr_ff <= 1'b0;
            if (op_ff == OP_CLEAR && cmd_ff.erase)
                free_ff <= 1'b0;
        end
    end

    // Row operation sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_ff <= OP_IDLE;
            cnt_ff <= RST_IDX;
            cmd_ff <= '0;
            beat_ff <= '0;
        end
        else
        begin
            beat_ff.valid <= 1'b0;
            case (op_ff)
                OP_IDLE:
                begin
                    cnt_ff <= RST_IDX;
                    if (do_prog)
                    begin
                        cmd_ff <= '{prog: 1'b1, erase: 1'b0, row: row}; // R1 R4
                        op_ff <= OP_STREAM;
                    end
                    else if (do_erase)
                    begin
                        cmd_ff <= '{prog: 1'b0, erase: 1'b1, row: row}; // R1
                        op_ff <= OP_WAIT;
                    end
                end
                OP_STREAM:
                begin
                    // All 32 latches go out, blanks included
                    beat_ff <= '{valid: 1'b1, idx: cnt_ff, data: lat_rd}; // R2 R4
                    cnt_ff <= cnt_ff + IDX_W'(1);
                    if (cnt_ff == LAST_IDX)
                        op_ff <= OP_WAIT;
                end
                OP_WAIT:
                    if (fl_done)
                        op_ff <= OP_CLEAR;
                OP_CLEAR:
                begin
                    cmd_ff <= '0;
                    cnt_ff <= RST_IDX;
                    op_ff <= OP_IDLE;
                end
                default:
                    op_ff <= OP_IDLE;
            endcase
        end
    end

    // Latches: load on unlocked start, blank after every program or erase
    frlws_latch_bank u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .load(do_load || do_prog), // R7 R8 R9
        .load_idx(adr_lo_ff[4:0]), // R3
        .load_data({word_hi_ff[5:0], word_lo_ff}),
        .blank_all(op_ff == OP_CLEAR), // R5 R6
        .rd_idx(cnt_ff),
        .rd_data(lat_rd)
    );

    // APB answer: one wait state, held off while a row operation runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= acc;
            pslverr_ff <= acc && !mapped(paddr);
            prdata_ff <= 32'h0000_0000;
            if (acc && !pwrite)
                case (paddr)
                    OFF_ADDR_LO: prdata_ff <= {24'h00_0000, adr_lo_ff};
                    OFF_ADDR_HI: prdata_ff <= {24'h00_0000, 1'b1, adr_hi_ff[6:0]};
                    OFF_WORD_LO: prdata_ff <= {24'h00_0000, word_lo_ff};
                    OFF_WORD_HI: prdata_ff <= {24'h00_0000, word_hi_ff};
                    OFF_CTRL1: prdata_ff <= {25'h000_0000, space_ff, latch_load_only_ff, free_ff,
                                             werr_ff, permit_ff, wr_ff, 1'b0};
                    default: prdata_ff <= 32'h0000_0000;
                endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign fl_cmd = cmd_ff;
    assign fl_beat = beat_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Only an unbroken pair counts; a stray access between the keys drops the first
    sequence s_keys;
        key_wr && pwdata[7:0] == KEY_FIRST && ul_ff == UL_IDLE
        ##[1:20] key_wr && pwdata[7:0] == KEY_SECOND && ul_ff == UL_GOT1;
    endsequence

    chk_load_only: assert property (do_load |=> op_ff == OP_IDLE && !cmd_ff.prog) // R7
        else $error("load-only start began a flash operation");
    chk_commit_go: assert property (do_prog |=> op_ff == OP_STREAM && cmd_ff.prog) // R8
        else $error("commit did not start streaming");
    chk_unlock_need: assert property ((do_load || do_prog || do_erase) |-> // R9
        $past(ul_ff) == UL_GOT1 || ul_ff == UL_ARMED)
        else $error("latch or flash action without unlock");
    chk_unlock_arm: assert property (s_keys |=> ul_ff == UL_ARMED) // R15
        else $error("key pair did not arm the start");
    chk_unlock_drop: assert property (acc && !key_wr |=> ul_ff == UL_IDLE) // R9
        else $error("stray access kept the unlock alive");
    chk_blank_after: assert property (op_ff == OP_CLEAR |=> lat_rd == BLANK_WORD) // R5 R6
        else $error("latch not blank after operation");
    chk_row_steady: assert property (op_ff == OP_STREAM && $past(op_ff) == OP_STREAM
        |-> $stable(cmd_ff.row)) // R4
        else $error("row changed during commit");
    chk_beat_order: assert property (fl_beat.valid && fl_beat.idx != LAST_IDX
        |=> fl_beat.valid && fl_beat.idx == $past(fl_beat.idx) + IDX_W'(1)) // R2
        else $error("commit beats out of order");
    chk_wp_reject: assert property (reject |=> werr_ff && !wr_ff && op_ff == OP_IDLE) // R16
        else $error("protected target not rejected");
    chk_no_erase: assert property (cmd_ff.prog |-> !cmd_ff.erase) // R1
        else $error("program carried an erase");
    chk_space_sel: assert property (trig && pwdata[B_SPACE] |=> op_ff == OP_IDLE) // R17 R18
        else $error("other space started a flash operation");
endmodule : frlws_seq

/* File: bench/frlws_flash_model.sv */
`timescale 1ns/10ps
module frlws_flash_model
    import frlws_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input frlws_cmd_t fl_cmd, // Row command from the sequencer
    input frlws_beat_t fl_beat, // Word beats of a commit
    input wire logic [7:0] dly, // Extra busy cycles, slow array
    output logic fl_done // End of the row operation
);
    logic [13:0] mem_ff [LATCHES];
    logic [9:0] row_ff;
    logic [9:0] cnt_ff;
    logic busy_ff;
    logic bad_ff;
    int nbeat_ff;
    int nprog_ff;
    int nerase_ff;
    wire [9:0] lim = {2'b00, dly} + (fl_cmd.prog ? 10'd33 : 10'd1);

    // Done comes only after all beats, so a short answer never cuts a row
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 10'h000;
            fl_done <= 1'b0;
            bad_ff <= 1'b0;
            row_ff <= 10'h000;
            nbeat_ff <= 0;
            nprog_ff <= 0;
            nerase_ff <= 0;
        end
        else
        begin
            fl_done <= busy_ff && (cnt_ff == lim);
            bad_ff <= bad_ff | (fl_cmd.prog & fl_cmd.erase);
            if (!busy_ff && (fl_cmd.prog || fl_cmd.erase))
            begin
                busy_ff <= 1'b1;
                cnt_ff <= 10'h000;
                row_ff <= fl_cmd.row;
                nbeat_ff <= 0;
                nprog_ff <= nprog_ff + int'(fl_cmd.prog);
                nerase_ff <= nerase_ff + int'(fl_cmd.erase);
            end
            else if (busy_ff && !(fl_cmd.prog || fl_cmd.erase))
                busy_ff <= 1'b0;
            else if (busy_ff && cnt_ff <= lim)
                cnt_ff <= cnt_ff + 10'h001;
            if (fl_beat.valid)
            begin
                mem_ff[fl_beat.idx] <= fl_beat.data;
                nbeat_ff <= nbeat_ff + 1;
            end
        end
    end
endmodule : frlws_flash_model

/* File: bench/flash_row_write_latch_sequencer_test.sv */
`timescale 1ns/10ps
module flash_row_write_latch_sequencer_test
    import frlws_pkg::*;
;
    localparam logic [31:0] C_PERM = 32'(1 << B_PERMIT);
    localparam logic [31:0] C_WR = 32'(1 << B_WR);
    localparam logic [31:0] C_LW = 32'(1 << B_LOAD_ONLY);
    localparam logic [31:0] C_FREE = 32'(1 << B_FREE);
    localparam logic [31:0] C_ERR = 32'(1 << B_WERR);
    localparam logic [31:0] C_SP = 32'(1 << B_SPACE);
    localparam logic [31:0] C_LOAD = C_PERM | C_LW | C_WR;
    localparam logic [31:0] C_COMMIT = C_PERM | C_WR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [9:0] wp_rows = 10'h000;
    logic [7:0] dly = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    frlws_cmd_t fl_cmd;
    frlws_beat_t fl_beat;
    logic fl_done;
    logic [13:0] img [LATCHES];
    logic [31:0] rdat;
    logic rerr;
    int n_fail = 0;
    int checks_done = 0;
    int np;
    int tr [4] = '{5, 192, 6, 10};
    int tw [4] = '{10, 0, 0, 10};
    int te [4] = '{1, 1, 1, 0};

    always #25 pclk = ~pclk;

    frlws_seq #(.FLASH_ROWS(10'd192)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wp_rows(wp_rows), .fl_done(fl_done),
        .fl_cmd(fl_cmd), .fl_beat(fl_beat));
    frlws_flash_model u_flash (.pclk(pclk), .presetn(presetn), .fl_cmd(fl_cmd),
        .fl_beat(fl_beat), .dly(dly), .fl_done(fl_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rdat & m, e, "register read");
        chk({31'h0000_0000, rerr}, 32'h0000_0000, "slave error");
    endtask : rdm

    task automatic unlock(input logic [31:0] ctl);
        wr(OFF_UNLOCK, {24'h00_0000, KEY_FIRST});
        wr(OFF_UNLOCK, {24'h00_0000, KEY_SECOND});
        wr(OFF_CTRL1, ctl);
    endtask : unlock

    task automatic ld(input logic [9:0] r, input logic [4:0] i, input logic [13:0] d,
        input logic [31:0] ctl);
        wr(OFF_ADDR_LO, {24'h00_0000, r[2:0], i});
        wr(OFF_ADDR_HI, {25'h000_0000, r[9:3]});
        wr(OFF_WORD_LO, {24'h00_0000, d[7:0]});
        wr(OFF_WORD_HI, {26'h000_0000, d[13:8]});
        unlock(ctl);
        img[i] = d;
    endtask : ld

    // Read stalls until the row operation is over, then compare the row
    task automatic chk_row(input logic [9:0] r);
        rdm(OFF_CTRL1, C_WR | C_ERR, 32'h0000_0000);
        chk({22'h00_0000, u_flash.row_ff}, {22'h00_0000, r}, "row");
        chk(u_flash.nbeat_ff, 32, "beat count");
        for (int i = 0; i < LATCHES; i++)
            chk({18'h0_0000, u_flash.mem_ff[i]}, {18'h0_0000, img[i]}, "latch word");
        foreach (img[i])
            img[i] = BLANK_WORD;
    endtask : chk_row

    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        foreach (img[i])
            img[i] = BLANK_WORD;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdm(OFF_CTRL1, 32'hFFFF_FFFF, 32'h0000_0000);
        rdm(OFF_ADDR_HI, 32'hFFFF_FFFF, 32'h0000_0080);
        xfer(1'b0, 12'h018, 32'h0000_0000);
        chk({31'h0000_0000, rerr}, 32'h0000_0001, "unmapped error");
        chk(rdat, 32'h0000_0000, "unmapped data");
        // Three loads, two broken unlocks, then the last word commits
        wr(OFF_CTRL1, C_PERM | C_LW);
        ld(10'd5, 5'd0, 14'h1234, C_LOAD);
        ld(10'd5, 5'd1, 14'h0ABC, C_LOAD);
        ld(10'd5, 5'd2, 14'h2001, C_LOAD);
        chk(u_flash.nprog_ff, 0, "load only programmed");
        wr(OFF_ADDR_LO, 32'h0000_00A3);
        wr(OFF_WORD_LO, 32'h0000_0077);
        wr(OFF_UNLOCK, {24'h00_0000, KEY_FIRST});
        xfer(1'b0, OFF_ADDR_LO, 32'h0000_0000);
        wr(OFF_UNLOCK, {24'h00_0000, KEY_SECOND});
        wr(OFF_CTRL1, C_LOAD);
        wr(OFF_UNLOCK, {24'h00_0000, KEY_FIRST});
        wr(OFF_CTRL1, C_LOAD);
        rdm(OFF_CTRL1, C_ERR | C_WR, C_ERR);
        wr(OFF_CTRL1, C_PERM | C_LW);
        ld(10'd5, 5'd31, 14'h0155, C_COMMIT);
        chk_row(10'd5);
        chk({31'h0000_0000, u_flash.bad_ff}, 32'h0000_0000, "erase with program");
        // Slow array; a fresh commit sees latches blank again
        dly <= 8'd200;
        ld(10'd6, 5'd4, 14'h0A5A, C_COMMIT);
        chk_row(10'd6);
        // Erase blanks a latch loaded before it
        dly <= 8'd0;
        ld(10'd7, 5'd0, 14'h1111, C_LOAD);
        img[0] = BLANK_WORD;
        np = u_flash.nerase_ff;
        unlock(C_PERM | C_FREE | C_WR);
        rdm(OFF_CTRL1, C_FREE | C_WR, 32'h0000_0000);
        chk(u_flash.nerase_ff, np + 1, "erase count");
        chk(u_flash.nbeat_ff, 0, "erase beats");
        ld(10'd7, 5'd1, 14'h2222, C_COMMIT);
        chk_row(10'd7);
        // Row bits span the high byte and the top of the low byte
        ld(10'h029, 5'h1F, 14'h3ABC, C_COMMIT);
        chk_row(10'h029);
        // Protected, past the top, other space, then the first open row
        for (int i = 0; i < 4; i++)
        begin
            wp_rows <= 10'(tw[i]);
            wr(OFF_CTRL1, C_PERM | C_LW);
            np = u_flash.nprog_ff;
            ld(10'(tr[i]), 5'd0, 14'h0001, C_COMMIT | (i == 2 ? C_SP : 32'h0000_0000));
            rdm(OFF_CTRL1, C_ERR | C_WR, te[i] != 0 ? C_ERR : 32'h0000_0000);
            chk(u_flash.nprog_ff, np + 1 - te[i], "program count");
        end
        tally_and_finish;
    end

    // Watchdog well beyond the fewer than one thousand cycles the tests need
    initial
    begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule : flash_row_write_latch_sequencer_test
